// >>> common/pchc_pkg.sv
// Package with shared constants and types for the peak-current PWM hiccup controller
package pchc_pkg;

  // ***************************************************************
  // Duty-limit strap decode
  // ***************************************************************
  typedef enum logic [1:0] {
    pchc_duty_100,
    pchc_duty_75,
    pchc_duty_50
  } pchc_duty_t;

  // Strap states as seen by the pad sensor: tied high, floating, tied low
  localparam logic [1:0] STRAP_RAIL = 2'h2;
  localparam logic [1:0] STRAP_FLOAT = 2'h1;
  localparam logic [1:0] STRAP_GND = 2'h0;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_MHZ = 200;
  localparam int LOGIC_DELAY_NS = 10;
  localparam int LOGIC_DELAY_CYC = (LOGIC_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] LOGIC_DELAY = CNT_W'(LOGIC_DELAY_CYC);

  // Previous-duty figure counts in quarters of the switching period
  localparam int PERIOD_W = 16;
  localparam int QUARTER_SHIFT = 2;

  // ***************************************************************
  // Control states
  // ***************************************************************
  typedef enum logic [2:0] {
    pchc_st_gap_sp,
    pchc_st_on,
    pchc_st_off,
    pchc_st_gap_ps,
    pchc_st_rect
  } pchc_phase_t;

  typedef enum logic [1:0] {
    pchc_hc_run,
    pchc_hc_charge,
    pchc_hc_wait
  } pchc_hiccup_t;

endpackage

// >>> core/pchc_sync.sv
// Two-stage synchroniser for a vector of asynchronous inputs
`timescale 1ns/100ps
module pchc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
    if (!resetn) begin
      meta_nxt = '0;
      sync_nxt = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    meta_r <= meta_nxt;
    sync_out <= sync_nxt;
  end

endmodule

// >>> core/pchc_ctrl.sv
// Switching-cycle control: PWM, duty limit, pulse skipping, current limit, hiccup
`timescale 1ns/100ps
module pchc_ctrl #(
  parameter int CW = pchc_pkg::CNT_W,
  parameter int PW = pchc_pkg::PERIOD_W
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cycle_start,
  input wire logic clk_high_phase,
  input wire logic [1:0] duty_limit_strap,
  input wire logic peak_cmp,
  input wire logic current_limit_cmp,
  input wire logic error_low_cmp,
  input wire logic soft_start_done_cmp,
  input wire logic hiccup_high_cmp,
  input wire logic hiccup_top_cmp,
  input wire logic hiccup_low_cmp,
  input wire logic [CW-1:0] blank_time_pin,
  input wire logic [CW-1:0] primary_to_rectifier_gap,
  input wire logic [CW-1:0] rectifier_to_primary_gap,
  output logic primary_drive_a,
  output logic primary_drive_b,
  output logic rectifier_drive_a,
  output logic rectifier_drive_b,
  output logic hiccup_charge_en,
  output logic hiccup_pullup_en,
  output logic hiccup_discharge_en,
  output logic soft_start_discharge
);

  // ***************************************************************
  // Input synchronisers
  // ***************************************************************
  localparam int NS = 7;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] syn;
  assign raw_in = {peak_cmp, current_limit_cmp, error_low_cmp, soft_start_done_cmp,
                   hiccup_high_cmp, hiccup_top_cmp, hiccup_low_cmp};

  pchc_sync #(.WIDTH(NS)) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .async_in(raw_in),
    .sync_out(syn)
  );

  logic peak_s, ilim_s, err_low_s, ss_done_s, hic_hi_s, hic_top_s, hic_low_s;
  // Peak comparator output already includes the sense offset ahead of COMP/2
  assign {peak_s, ilim_s, err_low_s, ss_done_s, hic_hi_s, hic_top_s, hic_low_s} = syn;

  // ***************************************************************
  // Strap capture at reset release
  // ***************************************************************
  pchc_pkg::pchc_duty_t duty_r, duty_nxt;
  logic duty50;

  always_comb begin
    duty_nxt = duty_r;
    if (!resetn) begin
      if (duty_limit_strap == pchc_pkg::STRAP_GND) begin
        duty_nxt = pchc_pkg::pchc_duty_50;
      end else if (duty_limit_strap == pchc_pkg::STRAP_FLOAT) begin
        duty_nxt = pchc_pkg::pchc_duty_75;
      end else begin
        duty_nxt = pchc_pkg::pchc_duty_100;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    duty_r <= duty_nxt;
  end

  assign duty50 = (duty_r == pchc_pkg::pchc_duty_50);

  // ***************************************************************
  // Hiccup sequencer
  // ***************************************************************
  pchc_pkg::pchc_hiccup_t hc_r, hc_nxt;
  logic pull_r, pull_nxt, chg_r, chg_nxt;
  logic limit_hit;

  always_comb begin
    hc_nxt = hc_r;
    pull_nxt = pull_r;
    chg_nxt = chg_r;
    if (cycle_start) begin
      chg_nxt = 1'b0;
    end
    if (limit_hit) begin
      chg_nxt = 1'b1;
    end
    case (hc_r)
      pchc_pkg::pchc_hc_run: begin
        if (hic_hi_s) begin
          hc_nxt = pchc_pkg::pchc_hc_charge;
          pull_nxt = 1'b1;
          chg_nxt = 1'b0;
        end
      end
      pchc_pkg::pchc_hc_charge: begin
        chg_nxt = 1'b0;
        if (hic_top_s) begin
          hc_nxt = pchc_pkg::pchc_hc_wait;
          pull_nxt = 1'b0;
        end
      end
      pchc_pkg::pchc_hc_wait: begin
        chg_nxt = 1'b0;
        if (hic_low_s) begin
          hc_nxt = pchc_pkg::pchc_hc_run;
        end
      end
      default: hc_nxt = pchc_pkg::pchc_hc_run;
    endcase
    if (!resetn) begin
      hc_nxt = pchc_pkg::pchc_hc_run;
      pull_nxt = 1'b0;
      chg_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    hc_r <= hc_nxt;
    pull_r <= pull_nxt;
    chg_r <= chg_nxt;
  end

  logic halted;
  assign halted = (hc_r != pchc_pkg::pchc_hc_run);

  // ***************************************************************
  // Switching-cycle phase machine
  // ***************************************************************
  pchc_pkg::pchc_phase_t ph_r, ph_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [PW-1:0] per_cnt_r, per_cnt_nxt, per_len_r, per_len_nxt;
  logic [PW-1:0] on_cnt_r, on_cnt_nxt, last_on_r, last_on_nxt;
  logic sel_b_r, sel_b_nxt;
  logic pa_nxt, pb_nxt, ra_nxt, rb_nxt;
  logic min_on_done, short_duty, skip_now, duty_cap, rect_ok;

  assign min_on_done = (cnt_r == pchc_pkg::CNT_ZERO);
  assign limit_hit = (ph_r == pchc_pkg::pchc_st_on) && min_on_done && ilim_s && !halted;
  // Previous on-time under a quarter of the previous period
  assign short_duty = (last_on_r < (per_len_r >> pchc_pkg::QUARTER_SHIFT));
  assign skip_now = err_low_s && short_duty;
  assign rect_ok = ss_done_s && !halted;
  // 75% limit taken from the clock's high phase; only as exact as the clock duty
  assign duty_cap = (duty_r == pchc_pkg::pchc_duty_75) ? !clk_high_phase :
                    (duty50 ? cycle_start : 1'b0);

  always_comb begin
    ph_nxt = ph_r;
    cnt_nxt = (cnt_r == pchc_pkg::CNT_ZERO) ? cnt_r : cnt_r - pchc_pkg::CNT_ONE;
    per_cnt_nxt = per_cnt_r + PW'(1);
    per_len_nxt = per_len_r;
    on_cnt_nxt = on_cnt_r;
    last_on_nxt = last_on_r;
    sel_b_nxt = sel_b_r;
    if (cycle_start) begin
      per_len_nxt = per_cnt_r;
      per_cnt_nxt = '0;
      last_on_nxt = on_cnt_r;
      on_cnt_nxt = '0;
    end
    case (ph_r)
      pchc_pkg::pchc_st_rect, pchc_pkg::pchc_st_off: begin
        if (cycle_start && !halted) begin
          // Alternate in 50% mode; a skip stays on the same drive so counts match
          if (skip_now) begin
            ph_nxt = ph_r;
          end else begin
            if (duty50) begin
              sel_b_nxt = !sel_b_r;
            end
            ph_nxt = pchc_pkg::pchc_st_gap_sp;
            cnt_nxt = rect_ok ? rectifier_to_primary_gap : pchc_pkg::CNT_ZERO;
          end
        end
      end
      pchc_pkg::pchc_st_gap_sp: begin
        if (min_on_done) begin
          ph_nxt = pchc_pkg::pchc_st_on;
          cnt_nxt = blank_time_pin + pchc_pkg::LOGIC_DELAY;
        end
      end
      pchc_pkg::pchc_st_on: begin
        on_cnt_nxt = on_cnt_r + PW'(1);
        if (halted) begin
          ph_nxt = pchc_pkg::pchc_st_off;
        end else if (min_on_done && (peak_s || ilim_s || duty_cap)) begin
          ph_nxt = pchc_pkg::pchc_st_gap_ps;
          cnt_nxt = primary_to_rectifier_gap;
        end
      end
      pchc_pkg::pchc_st_gap_ps: begin
        if (min_on_done) begin
          ph_nxt = pchc_pkg::pchc_st_rect;
        end
      end
      default: ph_nxt = pchc_pkg::pchc_st_off;
    endcase
    if (halted) begin
      ph_nxt = pchc_pkg::pchc_st_off;
    end
    if (!resetn) begin
      ph_nxt = pchc_pkg::pchc_st_off;
      cnt_nxt = '0;
      per_cnt_nxt = '0;
      per_len_nxt = '0;
      on_cnt_nxt = '0;
      last_on_nxt = '0;
      sel_b_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    ph_r <= ph_nxt;
    cnt_r <= cnt_nxt;
    per_cnt_r <= per_cnt_nxt;
    per_len_r <= per_len_nxt;
    on_cnt_r <= on_cnt_nxt;
    last_on_r <= last_on_nxt;
    sel_b_r <= sel_b_nxt;
  end

  // ***************************************************************
  // Output drives, all registered
  // ***************************************************************
  always_comb begin
    logic on_next, rect_next;
    on_next = (ph_nxt == pchc_pkg::pchc_st_on);
    // During a skipped cycle rectifiers stay on once soft-start has ended
    rect_next = rect_ok && ((ph_nxt == pchc_pkg::pchc_st_rect) ||
                            (ph_nxt == pchc_pkg::pchc_st_off));
    pa_nxt = on_next && !(duty50 && sel_b_nxt);
    pb_nxt = on_next && duty50 && sel_b_nxt;
    ra_nxt = rect_next && !(duty50 && !sel_b_nxt && on_next);
    rb_nxt = rect_next && duty50;
    if (!resetn) begin
      pa_nxt = 1'b0;
      pb_nxt = 1'b0;
      ra_nxt = 1'b0;
      rb_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    primary_drive_a <= pa_nxt;
    primary_drive_b <= pb_nxt;
    rectifier_drive_a <= ra_nxt;
    rectifier_drive_b <= rb_nxt;
    hiccup_charge_en <= chg_nxt;
    hiccup_pullup_en <= pull_nxt;
    hiccup_discharge_en <= resetn && (hc_nxt == pchc_pkg::pchc_hc_wait);
    soft_start_discharge <= resetn && (hc_nxt != pchc_pkg::pchc_hc_run);
  end

endmodule

// >>> sim/pchc_ctrl_chk.sv
// Port-level checker for the switching-cycle controller
`timescale 1ns/100ps
module pchc_ctrl_chk #(
  parameter int CW = pchc_pkg::CNT_W
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cycle_start,
  input wire logic [1:0] duty_limit_strap,
  input wire logic current_limit_cmp,
  input wire logic soft_start_done_cmp,
  input wire logic hiccup_low_cmp,
  input wire logic [CW-1:0] blank_time_pin,
  input wire logic primary_drive_a,
  input wire logic primary_drive_b,
  input wire logic rectifier_drive_a,
  input wire logic rectifier_drive_b,
  input wire logic hiccup_charge_en,
  input wire logic hiccup_pullup_en,
  input wire logic soft_start_discharge
);
  // ********
  // Helper state
  // ********
  logic half_r, half_nxt;
  logic [CW-1:0] on_r, on_nxt;
  always_comb begin
    // Strap only counts while reset holds, as in the design
    half_nxt = resetn ? half_r : (duty_limit_strap == pchc_pkg::STRAP_GND);
    on_nxt = primary_drive_a ? on_r + CW'(1) : '0;
  end
  always_ff @(posedge clk_sys) begin
    half_r <= half_nxt;
    on_r <= on_nxt;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_b_half; !half_r |-> !primary_drive_b && !rectifier_drive_b; endproperty
  a_b_half: assert property (p_b_half) else $error("b drive on");
  property p_rect_ss; !soft_start_done_cmp [*5] |-> !rectifier_drive_a && !rectifier_drive_b; endproperty
  a_rect_ss: assert property (p_rect_ss) else $error("rect in soft start");
  property p_min_on; $fell(primary_drive_a) && !soft_start_discharge |-> on_r >= blank_time_pin + pchc_pkg::LOGIC_DELAY; endproperty
  a_min_on: assert property (p_min_on) else $error("pulse too short");
  property p_lim_off; current_limit_cmp [*4] |-> !(primary_drive_a && on_r > blank_time_pin + 8'h4); endproperty
  a_lim_off: assert property (p_lim_off) else $error("limit ignored");
  property p_chg_cause; $rose(hiccup_charge_en) |-> $past(current_limit_cmp, 2) || $past(current_limit_cmp, 3); endproperty
  a_chg_cause: assert property (p_chg_cause) else $error("charge without limit");
  property p_chg_hold; hiccup_charge_en && !cycle_start |=> hiccup_charge_en || soft_start_discharge; endproperty
  a_chg_hold: assert property (p_chg_hold) else $error("charge dropped");
  property p_stop; soft_start_discharge |-> !primary_drive_a && !primary_drive_b; endproperty
  a_stop: assert property (p_stop) else $error("switching in shutdown");
  property p_pull; hiccup_pullup_en |-> soft_start_discharge; endproperty
  a_pull: assert property (p_pull) else $error("pull-up outside shutdown");
  property p_stay; soft_start_discharge && !hiccup_low_cmp |=> soft_start_discharge; endproperty
  a_stay: assert property (p_stay) else $error("early restart");
endmodule
bind pchc_ctrl pchc_ctrl_chk #(.CW(CW)) u_chk (
  .clk_sys(clk_sys), .resetn(resetn), .cycle_start(cycle_start),
  .duty_limit_strap(duty_limit_strap), .current_limit_cmp(current_limit_cmp),
  .soft_start_done_cmp(soft_start_done_cmp), .hiccup_low_cmp(hiccup_low_cmp),
  .blank_time_pin(blank_time_pin), .primary_drive_a(primary_drive_a),
  .primary_drive_b(primary_drive_b), .rectifier_drive_a(rectifier_drive_a),
  .rectifier_drive_b(rectifier_drive_b), .hiccup_charge_en(hiccup_charge_en),
  .hiccup_pullup_en(hiccup_pullup_en), .soft_start_discharge(soft_start_discharge)
);

// >>> sim/pchc_gate_model.sv
// Gate-driver stand-in: counts drive pulses and cross-conduction
`timescale 1ns/100ps
module pchc_gate_model (
  input wire logic clk_sys,
  input wire logic clr,
  input wire logic pa,
  input wire logic pb,
  input wire logic ra,
  input wire logic rb,
  output int n_a,
  output int n_b,
  output int n_rb,
  output int n_x
);
  logic [2:0] q;
  always @(posedge clk_sys) begin
    q <= {pa, pb, rb};
    if (clr) begin
      n_a <= 0;
      n_b <= 0;
      n_rb <= 0;
      n_x <= 0;
    end else begin
      n_a <= n_a + int'(pa && !q[2]);
      n_b <= n_b + int'(pb && !q[1]);
      n_rb <= n_rb + int'(rb && !q[0]);
      // Each of these overlaps would short a real bridge leg
      n_x <= n_x + int'((pa && ra) || (pb && rb) || (pb && ra) || (pa && pb));
    end
  end
endmodule

// >>> sim/peak_current_pwm_hiccup_ctrl_tb_top.sv
// Self-checking bench for the switching-cycle controller
`timescale 1ns/100ps
module peak_current_pwm_hiccup_ctrl_tb_top;
  logic clk_sys = 1'h0, resetn = 1'h0, cs = 1'h0, hp = 1'h0, pk = 1'h0, lim = 1'h0;
  logic elow = 1'h0, ssd = 1'h0, hh = 1'h0, ht = 1'h0, hl = 1'h1, clr = 1'h1, re = 1'h0;
  logic [1:0] strap = 2'h0;
  logic [7:0] blk = 8'h4, gps = 8'h1, gsp = 8'h1;
  logic pa, pb, ra, rb, ce, pu, de, ssdis;
  int n_a, n_b, n_rb, n_x;
  int n_mismatch = 0;
  int checks_done = 0;
  always #2.5 clk_sys = ~clk_sys;
  pchc_ctrl uut (
    .clk_sys(clk_sys), .resetn(resetn), .cycle_start(cs), .clk_high_phase(hp),
    .duty_limit_strap(strap), .peak_cmp(pk), .current_limit_cmp(lim), .error_low_cmp(elow),
    .soft_start_done_cmp(ssd), .hiccup_high_cmp(hh), .hiccup_top_cmp(ht),
    .hiccup_low_cmp(hl), .blank_time_pin(blk), .primary_to_rectifier_gap(gps),
    .rectifier_to_primary_gap(gsp), .primary_drive_a(pa), .primary_drive_b(pb),
    .rectifier_drive_a(ra), .rectifier_drive_b(rb), .hiccup_charge_en(ce),
    .hiccup_pullup_en(pu), .hiccup_discharge_en(de), .soft_start_discharge(ssdis)
  );
  pchc_gate_model u_gate (
    .clk_sys(clk_sys), .clr(clr), .pa(pa), .pb(pb), .ra(ra), .rb(rb),
    .n_a(n_a), .n_b(n_b), .n_rb(n_rb), .n_x(n_x)
  );
  // ********
  // Tasks
  // ********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rst(input logic [1:0] s);
    @(negedge clk_sys);
    resetn = 1'h0;
    strap = s;
    {lim, hh, ht, elow, re} = 5'h0;
    hl = 1'h1;
    repeat (12) @(negedge clk_sys);
    resetn = 1'h1;
    ssd = 1'h1;
  endtask
  task automatic clear();
    @(negedge clk_sys);
    clr = 1'h1;
    @(negedge clk_sys);
    clr = 1'h0;
  endtask
  // Forty-cycle switching period, peak seen k cycles after start
  task automatic run(input int n, input int k);
    for (int c = 0; c < n; c++) begin
      for (int t = 0; t < 40; t++) begin
        @(negedge clk_sys);
        cs = (t == 0);
        hp = (t < 20);
        pk = (t >= k);
        if (t == 30 && re) elow = 1'($urandom_range(0, 1));
      end
    end
  endtask
  task automatic wt(ref logic s, input logic v);
    for (int i = 0; i < 40 && s !== v; i++)
      @(negedge clk_sys);
    chk(s, v);
  endtask
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    int m;
    m = $urandom(32'h62dd7e93);
    // Longest pulse with peak held high must stay under a quarter period so skips can occur
    blk = 8'(3 + $urandom_range(0, 2));
    gps = 8'($urandom_range(0, 2));
    gsp = 8'($urandom_range(0, 2));
    for (m = 0; m < 3; m++) begin
      rst(2'(m));
      run(1, 10);
      clear();
      run(8, 8 + $urandom_range(0, 4));
      chk(n_a, (m == 0) ? 4 : 8);
      chk(n_b, (m == 0) ? 4 : 0);
      chk(n_rb != 0, m == 0);
      clear();
      // No peak: only the duty cap can end a pulse
      run(8, 40);
      chk(n_a, (m == 0) ? n_b : ((m == 1) ? 8 : 1));
      chk(n_x, 0);
      $display("duty mode %0d done", m);
    end
    for (m = 0; m < 2; m++) begin
      rst(pchc_pkg::STRAP_GND);
      run(2, 10);
      re = m[0];
      clear();
      run(16, 0);
      chk(n_a >= n_b && n_a <= n_b + 1, 1'h1);
      chk(n_a + n_b < 16, m == 1);
      $display("skip case %0d done", m);
    end
    rst(pchc_pkg::STRAP_FLOAT);
    run(1, 10);
    lim = 1'h1;
    hl = 1'h0;
    clear();
    run(4, 30);
    chk(n_a, 4);
    chk(ce, 1'h1);
    hh = 1'h1;
    wt(ssdis, 1'h1);
    chk(pu, 1'h1);
    ssd = 1'h0;
    clear();
    run(2, 10);
    ht = 1'h1;
    wt(de, 1'h1);
    chk(pu, 1'h0);
    {ht, hh, lim} = 3'h0;
    run(2, 10);
    chk(n_a, 0);
    hl = 1'h1;
    wt(ssdis, 1'h0);
    clear();
    run(4, 10);
    chk(n_a, 4);
    $display("hiccup test done");
    report_and_stop();
  end
endmodule
